// *** core_model.sv ***
// core side model: takes requests and acknowledges the non-maskable one
`timescale 1ns/1ps
module core_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic irq_i,
	input wire logic nmi_i,
	input wire logic slow_i,
	output logic ack_o
);
	int wait_q;
	// ******************************************************************
	// acknowledge
	// ******************************************************************
	// only the nmi is acked here, maskable flags are cleared by software
	// no masking in the core, global gating sits in the device
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_o <= 1'h0;
			wait_q <= 0;
		end else begin
			ack_o <= 1'h0;
			wait_q <= 0;
			if (irq_i && nmi_i && !ack_o) begin
				if (wait_q >= (slow_i ? 4 : 0))
					ack_o <= 1'h1;
				else
					wait_q <= wait_q + 1;
			end
		end
	end
endmodule

// *** irq_vec_map.sv ***
// module: interrupt flags, enables and fixed vector request selection
`timescale 1ns/1ps
module irq_vec_map
	import irq_vec_pkg::*;
#(
	parameter logic [1:0] PIN_VARIANT = PINS_48
) (
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	input wire src_ctl_s SRC_I,
	input wire logic GLOBAL_EN_I,
	input wire logic ACK_I,
	output logic [NUM_VEC-1:0] FLAGS_O,
	output logic [NUM_VEC-1:0] ENABLES_O,
	output logic IRQ_O,
	output logic NMI_O,
	output logic [VEC_W-1:0] VEC_NUM_O,
	output logic [ADDR_W-1:0] VEC_ADDR_O
);

	// ****************************************************************
	// flags and enables
	// ****************************************************************
	logic [NUM_VEC-1:0] flag_q;
	logic [NUM_VEC-1:0] en_q;
	logic [NUM_VEC-1:0] present;
	logic [NUM_VEC-1:0] pend;
	logic [NUM_VEC-1:0] ack_clr;
	req_s req_d;

	genvar g;
	generate
		for (g = 0; g < NUM_VEC; g++) begin : g_src
			// absent vectors are tied off in smaller variants
			assign present[g] = (g != 0) && vec_present(g, PIN_VARIANT);
			// set wins over clear so a same-cycle event is not lost
			always_ff @(posedge CLK_I or negedge ARST_N_I) begin
				if (!ARST_N_I) begin
					flag_q[g] <= 1'b0;
				end else if (SRC_I.event_set[g] && present[g]) begin
					flag_q[g] <= 1'b1;
				end else if (SRC_I.flag_clr[g] || ack_clr[g]) begin
					flag_q[g] <= 1'b0;
				end
			end
			always_ff @(posedge CLK_I or negedge ARST_N_I) begin
				if (!ARST_N_I) begin
					en_q[g] <= 1'b0;
				end else if (SRC_I.enable_wr[g] && present[g]) begin
					en_q[g] <= SRC_I.enable_val[g];
				end
			end
			// the checksum alarm is non-maskable: no enable gate
			if (g == int'(V_NMI)) begin : g_nmi
				assign pend[g] = flag_q[g] && present[g];
			end else begin : g_mask
				assign pend[g] = flag_q[g] && en_q[g] && GLOBAL_EN_I;
			end
		end
	endgenerate

	// ****************************************************************
	// priority select: lowest vector number wins
	// ****************************************************************
	always_comb begin
		req_d = '{valid: 1'b0, nmi: 1'b0, num: RST_VEC, addr: RST_ADDR};
		for (int i = NUM_VEC - 1; i > 0; i--) begin
			if (pend[i]) begin
				req_d.valid = 1'b1;
				req_d.num = VEC_W'(i);
				req_d.nmi = (VEC_W'(i) == V_NMI);
				req_d.addr = vec_addr(VEC_W'(i));
			end
		end
	end
	// mapping fixed by index

	// acknowledge clears only the non-maskable flag; others need software
	always_comb begin
		ack_clr = RST_ZERO;
		ack_clr[V_NMI] = ACK_I && NMI_O;
	end

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			IRQ_O <= 1'b0;
			NMI_O <= 1'b0;
			VEC_NUM_O <= RST_VEC;
			VEC_ADDR_O <= RST_ADDR;
		end else begin
			IRQ_O <= req_d.valid;
			NMI_O <= req_d.nmi;
			VEC_NUM_O <= req_d.num;
			VEC_ADDR_O <= req_d.addr;
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			FLAGS_O <= RST_ZERO;
			ENABLES_O <= RST_ZERO;
		end else begin
			FLAGS_O <= flag_q;
			ENABLES_O <= en_q;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);

	a_flag_set_wins: assert property (
		SRC_I.event_set[V_VLM] |=> flag_q[V_VLM])
		else $error("event did not set its flag");
	a_enable_write: assert property (
		SRC_I.enable_wr[V_RTC] |=> en_q[V_RTC] == $past(SRC_I.enable_val[V_RTC]))
		else $error("enable bit not written");
	a_req_needs_both: assert property (
		IRQ_O && !NMI_O |-> $past(|(flag_q & en_q)))
		else $error("request without flag and enable");
	a_req_holds: assert property (
		IRQ_O && !$past(IRQ_O) ##0 (flag_q[VEC_NUM_O]
		&& !SRC_I.flag_clr[VEC_NUM_O] && !(ACK_I && NMI_O)
		&& (NMI_O || (GLOBAL_EN_I && en_q[VEC_NUM_O]
		&& !SRC_I.enable_wr[VEC_NUM_O]))) |=> IRQ_O)
		else $error("request dropped with flag still set");
	a_global_gate: assert property (
		!$past(GLOBAL_EN_I) && !$past(flag_q[V_NMI]) |-> !IRQ_O)
		else $error("request while globally disabled");
	a_addr_twice: assert property (
		IRQ_O |-> VEC_ADDR_O == {1'b0, VEC_NUM_O, 1'b0} && VEC_NUM_O != V_RESET)
		else $error("vector address not twice number");
	a_nmi_vector: assert property (
		NMI_O |-> VEC_ADDR_O == 8'h02 && IRQ_O)
		else $error("nmi not at address 0x02");
	a_port_b_pins_absent: assert property (
		PIN_VARIANT != PINS_48 |-> !flag_q[V_PORT_B_PINS])
		else $error("port b flag in small variant");
	a_sp3_absent: assert property (
		PIN_VARIANT < PINS_40 |-> !flag_q[V_SP3_TXC] && !flag_q[V_SP3_RX])
		else $error("serial port 3 flag in small variant");

	c_nmi_taken: cover property (NMI_O ##1 ACK_I);
	c_spp_req: cover property (IRQ_O && VEC_ADDR_O == 8'h20);
	c_adc_win: cover property (IRQ_O && VEC_NUM_O == V_ADC_WIN);
	c_set_clear: cover property (SRC_I.event_set[V_PORT_A_PINS] && SRC_I.flag_clr[V_PORT_A_PINS]);

endmodule

// *** irq_vec_pkg.sv ***
// package: vector numbers, addresses and source carriers for the request map
// Contract
// - a source event sets its flag bit in the peripheral flag register
// - software enables or disables each source with its own enable bit
// - a maskable source requests only while its enable and its flag are both set
// - a request stays active, level style, until its flag is cleared
// - nothing but the non-maskable interrupt is delivered unless interrupts are globally enabled
// - vector 1 at 0x02 carries the non-maskable checksum scan interrupt
// - vector 2 at 0x04 carries the voltage level monitor interrupt
// - vector 3 at 0x06 carries real-time counter overflow or compare
// - vector 4 at 0x08 carries the periodic tick interrupt
// - vector 5 at 0x0A carries the custom logic unit interrupt
// - timer type A: 0x0E overflow, 0x10 split underflow, 0x12 on compares
// - port externals: 0x0C port A, 0x28 port D, 0x30 port C
// - serial port 0: 0x22 receive, 0x24 data empty, 0x26 transmit done
// - serial peripheral port shares one vector, number 16, at 0x20
// - converter result ready at 0x2C, window compare at 0x2E
// - port B external is vector 34 at 0x44, largest variant only
// - serial port 3 vectors, ending 0x4E, only in two largest variants
package irq_vec_pkg;

	localparam int NUM_VEC = 40;
	localparam int VEC_W = 6;
	localparam int ADDR_W = 8;

	// ****************************************************************
	// vector numbers
	// ****************************************************************
	localparam logic [VEC_W-1:0] V_RESET = 6'h00;
	localparam logic [VEC_W-1:0] V_NMI = 6'h01;
	localparam logic [VEC_W-1:0] V_VLM = 6'h02;
	localparam logic [VEC_W-1:0] V_RTC = 6'h03;
	localparam logic [VEC_W-1:0] V_TICK = 6'h04;
	localparam logic [VEC_W-1:0] V_CLU = 6'h05;
	localparam logic [VEC_W-1:0] V_PORT_A_PINS = 6'h06;
	localparam logic [VEC_W-1:0] V_TA_OVF = 6'h07;
	localparam logic [VEC_W-1:0] V_TA_UNF = 6'h08;
	localparam logic [VEC_W-1:0] V_TA_CMP0 = 6'h09;
	localparam logic [VEC_W-1:0] V_SPP = 6'h10;
	localparam logic [VEC_W-1:0] V_SP0_RX = 6'h11;
	localparam logic [VEC_W-1:0] V_PORT_D_PINS = 6'h14;
	localparam logic [VEC_W-1:0] V_ADC_RDY = 6'h16;
	localparam logic [VEC_W-1:0] V_ADC_WIN = 6'h17;
	localparam logic [VEC_W-1:0] V_PORT_C_PINS = 6'h18;
	localparam logic [VEC_W-1:0] V_PORT_B_PINS = 6'h22;
	localparam logic [VEC_W-1:0] V_PORTE = 6'h23;
	localparam logic [VEC_W-1:0] V_TB3 = 6'h24;
	localparam logic [VEC_W-1:0] V_SP3_RX = 6'h25;
	localparam logic [VEC_W-1:0] V_SP3_TXC = 6'h27;

	// pin-count variants, smallest first
	localparam logic [1:0] PINS_28 = 2'h0;
	localparam logic [1:0] PINS_32 = 2'h1;
	localparam logic [1:0] PINS_40 = 2'h2;
	localparam logic [1:0] PINS_48 = 2'h3;

	localparam logic [NUM_VEC-1:0] RST_ZERO = 40'h00_0000_0000;
	localparam logic [VEC_W-1:0] RST_VEC = 6'h00;
	localparam logic [ADDR_W-1:0] RST_ADDR = 8'h00;

	// per-source event, flag clear and enable, bit index = vector number
	typedef struct packed {
		logic [NUM_VEC-1:0] event_set;
		logic [NUM_VEC-1:0] flag_clr;
		logic [NUM_VEC-1:0] enable_wr;
		logic [NUM_VEC-1:0] enable_val;
	} src_ctl_s;

	typedef struct packed {
		logic valid;
		logic nmi;
		logic [VEC_W-1:0] num;
		logic [ADDR_W-1:0] addr;
	} req_s;

	function automatic logic [ADDR_W-1:0] vec_addr(
		input logic [VEC_W-1:0] n);
		vec_addr = {1'b0, n, 1'b0};
	endfunction

	// vector exists in the given pin-count variant
	function automatic logic vec_present(input int n, input logic [1:0] pins);
		logic ok;
		ok = 1'b1;
		if (n == int'(V_PORT_B_PINS))
			ok = (pins == PINS_48);
		else if (n >= int'(V_PORTE))
			ok = (pins >= PINS_40);
		return ok;
	endfunction

endpackage

// *** tb.sv ***
// testbench: vector map, gating, level hold and nmi acknowledge
`timescale 1ns/1ps
module tb;
	import irq_vec_pkg::*;
	logic clk, rst_n, gen, ack, slow, irq, nmi, irq2;
	src_ctl_s src;
	logic [NUM_VEC-1:0] flags, ens;
	logic [VEC_W-1:0] vnum;
	logic [ADDR_W-1:0] vaddr;
	int n_fail = 0, total_checks = 0, cycles = 0;

	irq_vec_map irq_vec_map_i (.CLK_I(clk), .ARST_N_I(rst_n), .SRC_I(src),
		.GLOBAL_EN_I(gen), .ACK_I(ack), .FLAGS_O(flags), .ENABLES_O(ens),
		.IRQ_O(irq), .NMI_O(nmi), .VEC_NUM_O(vnum), .VEC_ADDR_O(vaddr));
	// small variant lacks port b and serial port 3 vectors
	irq_vec_map #(.PIN_VARIANT(PINS_32)) irq_vec_map_small_i (.CLK_I(clk),
		.ARST_N_I(rst_n), .SRC_I(src), .GLOBAL_EN_I(gen), .ACK_I(ack),
		.FLAGS_O(), .ENABLES_O(), .IRQ_O(irq2), .NMI_O(), .VEC_NUM_O(),
		.VEC_ADDR_O());
	core_model core_model_i (.clk_i(clk), .rst_n_i(rst_n), .irq_i(irq),
		.nmi_i(nmi), .slow_i(slow), .ack_o(ack));

	// ******************************************************************
	// helpers
	// ******************************************************************
	task automatic report_and_stop;
		if (n_fail == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// k: 0 event, 1 flag clear, 2 enable on, 3 enable off
	task automatic pulse(input int k, input int n);
		@(negedge clk);
		case (k)
			0: src.event_set[n] = 1'h1;
			1: src.flag_clr[n] = 1'h1;
			default: begin
				src.enable_wr[n] = 1'h1;
				src.enable_val[n] = (k == 2);
			end
		endcase
		@(negedge clk);
		src = '0;
	endtask

	// ******************************************************************
	// scenarios
	// ******************************************************************
	task automatic t_map;
		for (int n = 1; n < NUM_VEC; n++) begin
			pulse(0, n);
			@(negedge clk);
			chk(8'(flags[n]), 8'h01);
			chk(8'(irq), 8'h01);
			chk(8'(nmi), 8'(n == 1));
			chk(8'(vnum), 8'(n));
			chk(vaddr, 8'(n * 2));
			chk(8'(irq2), 8'(n < 34));
			if (n != 1)
				pulse(1, n);
			repeat (3) @(negedge clk);
			chk(8'(irq), 8'h00);
		end
	endtask

	task automatic t_gate;
		pulse(0, 0);
		repeat (2) @(negedge clk);
		chk(8'(irq), 8'h00);
		pulse(3, 2);
		pulse(0, 2);
		@(negedge clk);
		chk(8'(ens[2]), 8'h00);
		chk(8'(irq), 8'h00);
		pulse(2, 2);
		@(negedge clk);
		chk(8'(irq), 8'h01);
		gen = 1'h0;
		repeat (2) @(negedge clk);
		chk(8'(irq), 8'h00);
		slow = 1'h1;
		pulse(0, 1);
		@(negedge clk);
		chk(8'(nmi), 8'h01);
		repeat (8) @(negedge clk);
		chk(8'(irq), 8'h00);
		gen = 1'h1;
		repeat (6) @(negedge clk);
		chk(8'(vnum), 8'h02);
		pulse(1, 2);
		@(negedge clk);
		chk(8'(irq), 8'h00);
	endtask

	// ******************************************************************
	// main
	// ******************************************************************
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	// ceiling well above the roughly 350 cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			report_and_stop;
		end
	end

	initial begin
		rst_n = 1'h0;
		gen = 1'h1;
		slow = 1'h0;
		src = '0;
		repeat (8) @(negedge clk);
		rst_n = 1'h1;
		@(negedge clk);
		src.enable_wr = '1;
		src.enable_val = '1;
		@(negedge clk);
		src = '0;
		t_map;
		t_gate;
		report_and_stop;
	end
endmodule
